// >>> ffl_defines.svh
// register map, field positions and fixed codes of the fifo flag block
`ifndef FFL_DEFINES_SVH
`define FFL_DEFINES_SVH

`define FFL_ADDR_ALIGN     32'hFFFFFFFC
`define FFL_ADDR_CTRL      32'h00000000
`define FFL_ADDR_PFTH      32'h00000004
`define FFL_ADDR_PETH      32'h00000008
`define FFL_ADDR_STATUS    32'h0000000C
`define FFL_ADDR_IRQSTS    32'h00000010
`define FFL_ADDR_IRQMASK   32'h00000014

`define FFL_CTRL_MODE      1:0
`define FFL_CTRL_FLUSH     2
`define FFL_MODE_ILLEGAL   2'h3

`define FFL_ST_FULL        0
`define FFL_ST_AFULL       1
`define FFL_ST_PFULL       2
`define FFL_ST_EMPTY       3
`define FFL_ST_AEMPTY      4
`define FFL_ST_PEMPTY      5
`define FFL_ST_WRCNT_LSB   8
`define FFL_ST_RDCNT_LSB   16

`define FFL_IRQ_OVF        0
`define FFL_IRQ_UDF        1
`define FFL_IRQ_PFULL      2
`define FFL_IRQ_PEMPTY     3
`define FFL_IRQ_W          4

`define FFL_RESP_OKAY      2'h0
`define FFL_RESP_SLVERR    2'h2

`define FFL_ONE_LEFT       1

`endif

// >>> ffl_fifo_flags.sv
// fifo with mode-selectable flag timing and an axi4-lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ffl_defines.svh"

module ffl_fifo_flags
    import ffl_pkg::*;
#(
    parameter int WIDTH       = 32,
    parameter int DEPTH       = 16,
    parameter int SYNC_STAGES = 2,
    parameter int PF_RST      = DEPTH - 2,
    parameter int PE_RST      = 2,
    localparam int AW         = $clog2(DEPTH),
    localparam int CW         = AW + 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    output logic                  full,
    output logic                  almostFull,
    output logic                  progFull,
    output logic                  wrAck,
    output logic                  overflow,
    output logic [CW-1:0]         wrFillCount,
    input  wire logic             rdEn,
    output logic [WIDTH-1:0]      rdData,
    output logic                  empty,
    output logic                  almostEmpty,
    output logic                  progEmpty,
    output logic                  rdValid,
    output logic                  underflow,
    output logic [CW-1:0]         rdFillCount,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic                  irq
);

    typedef struct packed {
        ffl_mode_e                mode;
        logic                     flush;
        logic [CW-1:0]            pfTh;
        logic [CW-1:0]            peTh;
        logic [`FFL_IRQ_W-1:0]    irqSts;
        logic [`FFL_IRQ_W-1:0]    irqMask;
        logic                     irq;
        logic                     awHeld;
        logic                     wHeld;
        logic [31:0]              awAddr;
        logic [31:0]              wData;
        logic [3:0]               wStrb;
        logic                     awready;
        logic                     wready;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic [CW-1:0]            wrPtr;
        logic [CW-1:0]            rdPtr;
        logic [CW-1:0]            wrGray;
        logic [CW-1:0]            rdGray;
        logic [CW-1:0]            wrSeen;
        logic [CW-1:0]            rdSeen;
        logic                     stageVal;
        logic                     outVal;
        logic [WIDTH-1:0]         stageData;
        logic [WIDTH-1:0]         rdData;
        logic                     full;
        logic                     aFull;
        logic                     pFull;
        logic                     wrAck;
        logic                     ovf;
        logic [CW-1:0]            wrCnt;
        logic                     empty;
        logic                     aEmpty;
        logic                     pEmpty;
        logic                     valid;
        logic                     udf;
        logic [CW-1:0]            rdCnt;
    } ffl_state_s;

    ffl_state_s            q;
    ffl_state_s            d;
    // storage stays outside the state struct: an array of words, no reset needed
    logic [WIDTH-1:0]      mem [DEPTH];

    logic [CW-1:0]         wrGraySync;
    logic [CW-1:0]         rdGraySync;
    logic                  isFwft;
    logic                  isIndep;
    logic [CW-1:0]         rdViewW;
    logic [CW-1:0]         wrViewR;
    logic [CW-1:0]         curW;
    logic [CW-1:0]         curR;
    logic                  wrOk;
    logic                  rdOk;
    logic                  stageMove;
    logic                  pop;
    logic [CW-1:0]         nWrPtr;
    logic [CW-1:0]         nRdPtr;
    logic [CW-1:0]         nW;
    logic [CW-1:0]         nR;
    logic [CW-1:0]         nTotal;
    logic [WIDTH-1:0]      memRd;
    logic                  doWr;
    logic [31:0]           wv;
    logic [`FFL_IRQ_W-1:0] clrSts;
    logic [`FFL_IRQ_W-1:0] ev;

    function automatic logic [CW-1:0] bin2gray(input logic [CW-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    function automatic ffl_sel_e regSel(input logic [31:0] a);
        unique case (a & `FFL_ADDR_ALIGN)
            `FFL_ADDR_CTRL:    return FFL_SEL_CTRL;
            `FFL_ADDR_PFTH:    return FFL_SEL_PFTH;
            `FFL_ADDR_PETH:    return FFL_SEL_PETH;
            `FFL_ADDR_STATUS:  return FFL_SEL_STATUS;
            `FFL_ADDR_IRQSTS:  return FFL_SEL_IRQSTS;
            `FFL_ADDR_IRQMASK: return FFL_SEL_IRQMASK;
            default:           return FFL_SEL_NONE;
        endcase
    endfunction : regSel

    // counts are packed into byte fields; DEPTH above 128 would overrun them
    function automatic ffl_word_t regRead(input ffl_sel_e s, input ffl_state_s st);
        ffl_word_t w;
        w = '0;
        unique case (s)
            FFL_SEL_CTRL:    w[`FFL_CTRL_MODE] = st.mode;
            FFL_SEL_PFTH:    w[CW-1:0] = st.pfTh;
            FFL_SEL_PETH:    w[CW-1:0] = st.peTh;
            FFL_SEL_STATUS: begin
                w[`FFL_ST_FULL]              = st.full;
                w[`FFL_ST_AFULL]             = st.aFull;
                w[`FFL_ST_PFULL]             = st.pFull;
                w[`FFL_ST_EMPTY]             = st.empty;
                w[`FFL_ST_AEMPTY]            = st.aEmpty;
                w[`FFL_ST_PEMPTY]            = st.pEmpty;
                w[`FFL_ST_WRCNT_LSB +: CW]   = st.wrCnt;
                w[`FFL_ST_RDCNT_LSB +: CW]   = st.rdCnt;
            end
            FFL_SEL_IRQSTS:  w[`FFL_IRQ_W-1:0] = st.irqSts;
            FFL_SEL_IRQMASK: w[`FFL_IRQ_W-1:0] = st.irqMask;
            FFL_SEL_NONE:    w = '0;
        endcase
        return w;
    endfunction : regRead

    // pointer crossings; in common modes the synced copies are simply unused
    ffl_ptr_sync #(
        .W      (CW),
        .STAGES (SYNC_STAGES)
    ) u_wr_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .clr     (q.flush),
        .dIn     (q.wrGray),
        .dOut    (wrGraySync)
    );

    ffl_ptr_sync #(
        .W      (CW),
        .STAGES (SYNC_STAGES)
    ) u_rd_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .clr     (q.flush),
        .dIn     (q.rdGray),
        .dOut    (rdGraySync)
    );

    assign memRd = mem[q.rdPtr[AW-1:0]];

    always_comb begin
        d       = q;
        isFwft  = (q.mode == FFL_COMMON_FWFT);
        isIndep = (q.mode == FFL_INDEP_STD);
        // split sides see the far pointer only through the crossing
        rdViewW = isIndep ? gray2bin(q.rdSeen) : q.rdPtr;
        wrViewR = isIndep ? gray2bin(q.wrSeen) : q.wrPtr;
        curW    = q.wrPtr - rdViewW;
        curR    = isFwft ? (q.wrPtr - q.rdPtr + CW'(q.stageVal) + CW'(q.outVal))
                         : (wrViewR - q.rdPtr);
        wrOk    = wrEn && !q.full && !q.flush;
        rdOk    = rdEn && !q.flush && (isFwft ? q.outVal : !q.empty);
        // fall-through pipe: memory -> stage -> output word
        stageMove = q.stageVal && (!q.outVal || rdOk);
        pop       = isFwft ? ((q.wrPtr != q.rdPtr) && (!q.stageVal || stageMove)) : rdOk;
        nWrPtr    = q.wrPtr + CW'(wrOk);
        nRdPtr    = q.rdPtr + CW'(pop);
        d.wrPtr    = nWrPtr;
        d.rdPtr    = nRdPtr;
        d.stageVal = isFwft && (pop || (q.stageVal && !stageMove));
        d.outVal   = isFwft && (stageMove || (q.outVal && !rdOk));
        if (isFwft && pop) begin
            d.stageData = memRd;
        end
        if (isFwft ? stageMove : rdOk) begin
            d.rdData = isFwft ? q.stageData : memRd;
        end
        nTotal = nWrPtr - nRdPtr + CW'(d.stageVal) + CW'(d.outVal);
        nW     = nWrPtr - (isIndep ? rdViewW : nRdPtr);
        nR     = isIndep ? (wrViewR - nRdPtr) : nTotal;

        // write-side flags follow the same edge as the operation
        d.full  = (nW == CW'(DEPTH));
        d.aFull = (nW >= CW'(DEPTH - `FFL_ONE_LEFT));
        d.wrAck = wrOk;
        d.ovf   = wrEn && q.full;
        // read-side flags
        d.valid = rdOk;
        d.udf   = rdEn && !rdOk && !q.flush;
        d.empty = isFwft ? !d.outVal : (nR == '0);
        if (isFwft && !rdOk) begin
            d.aEmpty = (curR <= CW'(`FFL_ONE_LEFT));
        end else begin
            d.aEmpty = (nR <= CW'(`FFL_ONE_LEFT));
        end
        // compare of the already registered level costs one edge
        d.pFull  = (curW >= q.pfTh);
        d.pEmpty = (curR <= q.peTh);
        d.wrCnt  = isIndep ? curW : nTotal;
        d.rdCnt  = isIndep ? curR : nTotal;
        // gray register ahead of the chain adds the one extra edge
        d.wrGray = bin2gray(q.wrPtr);
        d.rdGray = bin2gray(q.rdPtr);
        // far side captures the chain output once more before its flags
        d.wrSeen = wrGraySync;
        d.rdSeen = rdGraySync;

        ev = '0;
        ev[`FFL_IRQ_OVF]    = d.ovf;
        ev[`FFL_IRQ_UDF]    = d.udf;
        ev[`FFL_IRQ_PFULL]  = d.pFull && !q.pFull;
        ev[`FFL_IRQ_PEMPTY] = d.pEmpty && !q.pEmpty;

        // axi4-lite write: address and data taken in either order
        clrSts  = '0;
        d.flush = 1'b0;
        doWr    = q.awHeld && q.wHeld && !q.bvalid;
        wv      = q.wData;
        if (q.awready && s_axi_awvalid) begin
            d.awHeld = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (q.wready && s_axi_wvalid) begin
            d.wHeld = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        d.bvalid = q.bvalid && !s_axi_bready;
        if (doWr) begin
            wv = regRead(regSel(q.awAddr), q);
            for (int i = 0; i < 4; i++) begin
                if (q.wStrb[i]) begin
                    wv[i*8 +: 8] = q.wData[i*8 +: 8];
                end
            end
            d.awHeld = 1'b0;
            d.wHeld  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `FFL_RESP_OKAY;
            unique case (regSel(q.awAddr))
                FFL_SEL_CTRL: begin
                    // a mode change always empties the fifo
                    if (wv[`FFL_CTRL_MODE] != `FFL_MODE_ILLEGAL) begin
                        d.mode  = ffl_mode_e'(wv[`FFL_CTRL_MODE]);
                        d.flush = wv[`FFL_CTRL_FLUSH] || (wv[`FFL_CTRL_MODE] != q.mode);
                    end else begin
                        d.flush = wv[`FFL_CTRL_FLUSH];
                    end
                end
                FFL_SEL_PFTH:    d.pfTh = wv[CW-1:0];
                FFL_SEL_PETH:    d.peTh = wv[CW-1:0];
                FFL_SEL_STATUS:  d.bresp = `FFL_RESP_OKAY;
                FFL_SEL_IRQSTS:  clrSts = wv[`FFL_IRQ_W-1:0];
                FFL_SEL_IRQMASK: d.irqMask = wv[`FFL_IRQ_W-1:0];
                FFL_SEL_NONE:    d.bresp = `FFL_RESP_SLVERR;
            endcase
        end
        d.awready = !d.awHeld;
        d.wready  = !d.wHeld;

        // axi4-lite read: one outstanding, data one edge after address
        d.rvalid = q.rvalid && !s_axi_rready;
        if (q.arready && s_axi_arvalid) begin
            d.rvalid = 1'b1;
            d.rdata  = regRead(regSel(s_axi_araddr), q);
            d.rresp  = (regSel(s_axi_araddr) == FFL_SEL_NONE) ? `FFL_RESP_SLVERR
                                                              : `FFL_RESP_OKAY;
        end
        d.arready = !d.rvalid;

        // set beats a same-cycle write-one-to-clear
        d.irqSts = (q.irqSts & ~clrSts) | ev;
        d.irq    = |(d.irqSts & d.irqMask);

        if (q.flush) begin
            d.wrPtr    = '0;
            d.rdPtr    = '0;
            d.wrGray   = '0;
            d.rdGray   = '0;
            d.wrSeen   = '0;
            d.rdSeen   = '0;
            d.stageVal = 1'b0;
            d.outVal   = 1'b0;
            d.full     = 1'b0;
            d.aFull    = 1'b0;
            d.pFull    = 1'b0;
            d.empty    = 1'b1;
            d.aEmpty   = 1'b1;
            d.pEmpty   = 1'b0;
            d.wrCnt    = '0;
            d.rdCnt    = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            q.mode    <= FFL_COMMON_STD;
            q.pfTh    <= CW'(PF_RST);
            q.peTh    <= CW'(PE_RST);
            q.empty   <= 1'b1;
            q.aEmpty  <= 1'b1;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && wrOk) begin
            mem[q.wrPtr[AW-1:0]] <= wrData;
        end
    end

    assign full          = q.full;
    assign almostFull    = q.aFull;
    assign progFull      = q.pFull;
    assign wrAck         = q.wrAck;
    assign overflow      = q.ovf;
    assign wrFillCount   = q.wrCnt;
    assign rdData        = q.rdData;
    assign empty         = q.empty;
    assign almostEmpty   = q.aEmpty;
    assign progEmpty     = q.pEmpty;
    assign rdValid       = q.valid;
    assign underflow     = q.udf;
    assign rdFillCount   = q.rdCnt;
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rvalid  = q.rvalid;
    assign irq           = q.irq;

endmodule : ffl_fifo_flags

// >>> ffl_fifo_flags_checker.sv
// concurrent checks on the fifo flag ports
`timescale 1ns/1ns
module ffl_fifo_flags_checker #(
    parameter int DEPTH = 16,
    localparam int CW   = $clog2(DEPTH) + 1
) (
    input wire logic          clk_sys,
    input wire logic          rst_n,
    input wire logic          ce,
    input wire logic          wrEn,
    input wire logic          rdEn,
    input wire logic          full,
    input wire logic          almostFull,
    input wire logic          progFull,
    input wire logic          wrAck,
    input wire logic          overflow,
    input wire logic          empty,
    input wire logic          progEmpty,
    input wire logic          rdValid,
    input wire logic          underflow,
    input wire logic          irq,
    input wire logic [CW-1:0] rdFillCount
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // a frozen clock enable holds the pulses, so only judge after an enabled edge
    AST_ACK_CAUSE: assert property ($past(ce) && wrAck |-> $past(wrEn) && !$past(full) && !overflow)
        else $error("write ack without an accepted write");
    AST_OVF_CAUSE: assert property ($past(ce) && overflow |-> $past(wrEn) && $past(full))
        else $error("overflow without a write into a full fifo");
    AST_VALID_CAUSE: assert property ($past(ce) && rdValid |-> $past(rdEn) && !$past(empty) && !underflow)
        else $error("read valid without an accepted read");
    AST_UDF_CAUSE: assert property ($past(ce) && underflow |-> $past(rdEn))
        else $error("underflow without a read request");
    AST_WR_TAKEN: assert property (ce && wrEn && !full |=> wrAck)
        else $error("accepted write not acknowledged on its own edge");
    AST_FULL_RISE: assert property ($rose(full) |-> wrAck)
        else $error("full rose without a write on that edge");
    AST_PFULL_LAG: assert property ($rose(progFull) |-> $past(wrAck))
        else $error("prog full rose without a write one edge before");
    AST_PEMPTY_LAG: assert property ($rose(progEmpty) |-> $past(rdValid) || $past(rdFillCount) == '0)
        else $error("prog empty rose without a read one edge before");
    AST_FULL_NEST: assert property (full |-> almostFull)
        else $error("full without almost full");
    COV_OVF: cover property (overflow);
    COV_FILL: cover property ($fell(empty) ##[1:8] rdValid);
    COV_IRQ: cover property (irq);
endmodule : ffl_fifo_flags_checker

bind ffl_fifo_flags ffl_fifo_flags_checker #(.DEPTH(DEPTH)) u_chk (
    .clk_sys, .rst_n, .ce, .wrEn, .rdEn, .full, .almostFull, .progFull, .wrAck, .overflow,
    .empty, .progEmpty, .rdValid, .underflow, .irq, .rdFillCount
);

// >>> ffl_pkg.sv
// types shared by the fifo flag block
package ffl_pkg;

    typedef enum logic [1:0] {
        FFL_COMMON_STD,
        FFL_COMMON_FWFT,
        FFL_INDEP_STD
    } ffl_mode_e;

    typedef enum logic [2:0] {
        FFL_SEL_CTRL,
        FFL_SEL_PFTH,
        FFL_SEL_PETH,
        FFL_SEL_STATUS,
        FFL_SEL_IRQSTS,
        FFL_SEL_IRQMASK,
        FFL_SEL_NONE
    } ffl_sel_e;

    typedef logic [31:0] ffl_word_t;

endpackage : ffl_pkg

// >>> ffl_ptr_sync.sv
// multi-stage synchroniser chain for a gray-coded pointer
`timescale 1ns/1ns
module ffl_ptr_sync
    import ffl_pkg::*;
#(
    parameter int W      = 5,
    parameter int STAGES = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         clr,
    input  wire logic [W-1:0] dIn,
    output logic      [W-1:0] dOut
);

    typedef struct packed {
        logic [STAGES-1:0][W-1:0] chain;
    } ffl_sync_s;

    ffl_sync_s q;
    ffl_sync_s d;

    // stage count sets the crossing latency term
    always_comb begin
        d = q;
        d.chain[0] = dIn;
        for (int i = 1; i < STAGES; i++) begin
            d.chain[i] = q.chain[i-1];
        end
        if (clr) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // only the last stage leaves the chain
    assign dOut = q.chain[STAGES-1];

endmodule : ffl_ptr_sync

// >>> ffl_stream_partner.sv
// producer and consumer logic on the fifo stream ports
`timescale 1ns/1ns
module ffl_stream_partner #(
    parameter int WIDTH = 32
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wrCmd,
    input  wire logic        rdCmd,
    input  wire logic        full,
    output logic             wrEn,
    output logic [WIDTH-1:0] wrData,
    output logic             rdEn
);
    logic [WIDTH-1:0] seq_ff;
    logic [WIDTH-1:0] nxt_seq;
    // a refused word is offered again, so read order has no gaps
    assign nxt_seq = seq_ff + WIDTH'(wrEn && !full);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= WIDTH'(1);
            wrEn   <= 1'b0;
            rdEn   <= 1'b0;
            wrData <= '0;
        end else begin
            seq_ff <= nxt_seq;
            wrEn   <= wrCmd;
            rdEn   <= rdCmd;
            // idle bus toggles, never a stale word
            wrData <= wrCmd ? nxt_seq : ~wrData;
        end
    end
endmodule : ffl_stream_partner

// >>> tb_top.sv
// self-checking bench for the fifo flag block
`timescale 1ns/1ns
`include "ffl_defines.svh"
module tb_top;
    localparam int DEPTH = 4;
    localparam int SYNC  = 2;
    typedef struct packed {
        logic w, r, f, af, e, ae, ack, ovf, val, udf;
        logic [2:0] cnt;
        logic pf, pe;
        logic [7:0] d;
    } ffl_row_s;
    // common standard mode, depth four, both thresholds two
    ffl_row_s rows [10] = '{'{0,1,0,0,1,1,0,0,0,1,0,0,1,0}, '{1,0,0,0,0,1,1,0,0,0,1,0,1,0},
        '{1,0,0,0,0,0,1,0,0,0,2,1,1,0}, '{1,0,0,1,0,0,1,0,0,0,3,1,0,0},
        '{1,0,1,1,0,0,1,0,0,0,4,1,0,0}, '{1,0,1,1,0,0,0,1,0,0,4,1,0,0},
        '{0,1,0,1,0,0,0,0,1,0,3,1,0,1}, '{0,1,0,0,0,0,0,0,1,0,2,1,1,2},
        '{0,1,0,0,0,1,0,0,1,0,1,0,1,3}, '{0,1,0,0,1,1,0,0,1,0,0,0,1,4}};
    logic [31:0] ra [5] = '{`FFL_ADDR_CTRL, `FFL_ADDR_PFTH, `FFL_ADDR_PETH, `FFL_ADDR_IRQMASK, 32'h18};
    logic [31:0] rv [5] = '{32'h0, 32'(DEPTH - 2), 32'h2, 32'h0, 32'h0};
    logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, wrCmd = 1'b0, rdCmd = 1'b0;
    logic wrEn, rdEn, full, almostFull, progFull, wrAck, overflow, irq, pf = 1'b0, pe = 1'b1;
    logic empty, almostEmpty, progEmpty, rdValid, underflow;
    logic [2:0] wrFillCount, rdFillCount;
    logic [31:0] wrData, rdData, s_axi_rdata, rdv, s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int failures = 0, nChecks = 0, k;
    ffl_row_s rw;
    always #25 clk_sys = ~clk_sys;
    ffl_fifo_flags #(.WIDTH(32), .DEPTH(DEPTH), .SYNC_STAGES(SYNC)) u_dut (
        .clk_sys, .rst_n, .ce, .wrEn, .wrData, .full, .almostFull, .progFull, .wrAck,
        .overflow, .wrFillCount, .rdEn, .rdData, .empty, .almostEmpty, .progEmpty, .rdValid,
        .underflow, .rdFillCount, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq);
    ffl_stream_partner #(.WIDTH(32)) u_partner (
        .clk_sys, .rst_n, .wrCmd, .rdCmd, .full, .wrEn, .wrData, .rdEn);
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        nChecks++;
        if (got !== ex) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    // partner lags the command by one edge, so the operation lands two edges on
    task automatic op(input logic w, input logic r);
        @(posedge clk_sys);
        wrCmd <= w;
        rdCmd <= r;
        @(posedge clk_sys);
        wrCmd <= 1'b0;
        rdCmd <= 1'b0;
        tick;
    endtask : op
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic end_of_test;
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            axi_rd(ra[i]);
            chk("regData", rv[i], rdv);
            chk("regResp", (i == 4) ? 32'(`FFL_RESP_SLVERR) : 32'h0, 32'(rsp));
        end
        $display("register reset test done");
        for (int i = 0; i < 10; i++) begin
            rw = rows[i];
            op(rw.w, rw.r);
            chk("flags", {rw.f, rw.af, rw.e, rw.ae, rw.ack, rw.ovf, rw.val, rw.udf},
                {full, almostFull, empty, almostEmpty, wrAck, overflow, rdValid, underflow});
            chk("counts", {rw.cnt, rw.cnt}, {wrFillCount, rdFillCount});
            chk("rdData", 32'(rw.d), rdData);
            chk("progBefore", {pf, pe}, {progFull, progEmpty});
            tick;
            chk("progAfter", {rw.pf, rw.pe, 1'b0}, {progFull, progEmpty, wrAck});
            pf = rw.pf;
            pe = rw.pe;
        end
        $display("common standard test done");
        axi_rd(`FFL_ADDR_IRQSTS);
        chk("irqSts", 32'hF, rdv);
        axi_wr(`FFL_ADDR_IRQMASK, 32'h1);
        tick;
        tick;
        chk("irqOn", 32'h1, 32'(irq));
        axi_wr(`FFL_ADDR_IRQSTS, 32'h1);
        tick;
        tick;
        chk("irqOff", 32'h0, 32'(irq));
        axi_rd(`FFL_ADDR_IRQSTS);
        chk("irqW1c", 32'hE, rdv);
        $display("interrupt test done");
        axi_wr(`FFL_ADDR_CTRL, 32'h1);
        repeat (4) tick;
        op(1'b1, 1'b0);
        chk("fwftCnt", 32'h9, {empty, wrFillCount});
        tick;
        chk("fwftEmpty1", 32'h1, 32'(empty));
        tick;
        chk("fwftHead", 32'h5, {empty, rdData[30:0]});
        op(1'b0, 1'b1);
        chk("fwftRead", 32'h28, {rdValid, underflow, empty, rdFillCount});
        $display("fall-through test done");
        axi_wr(`FFL_ADDR_CTRL, 32'h2);
        repeat (8) tick;
        op(1'b1, 1'b0);
        chk("indepWr", 32'h8, {wrAck, wrFillCount});
        tick;
        chk("indepWrCnt", 32'h1, 32'(wrFillCount));
        for (k = 1; empty === 1'b1 && k < 12; k++) tick;
        chk("emptyLat", 32'h1, 32'(k >= SYNC + 3 && k <= SYNC + 4));
        op(1'b0, 1'b1);
        chk("indepRd", 32'h19, {rdValid, empty, rdFillCount});
        tick;
        chk("indepRdCnt", 32'h0, 32'(rdFillCount));
        for (k = 1; wrFillCount !== 3'h0 && k < 12; k++) tick;
        chk("wrCntLat", 32'h1, 32'(k >= SYNC + 3 && k <= SYNC + 4));
        $display("split side test done");
        op(1'b1, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tick;
        chk("reset", 32'h60, {full, almostFull, progFull, empty, almostEmpty, wrAck, rdValid,
            wrFillCount});
        $display("reset test done");
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        end_of_test;
    end
endmodule : tb_top
